// ---- design/acsdf_pkg.sv ----
// Constants and types shared by the clock select and decimation block
package acsdf_pkg;

  // Register port geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned NUM_SETUPS = 8;
  localparam int unsigned SETUP_W = 3;

  // Register offsets
  localparam logic [7:0] MODE_CTRL_OFS = 8'h01;
  localparam logic [7:0] FILT_CFG_OFS = 8'h28;
  localparam logic [7:0] STATUS_OFS = 8'h38;
  localparam logic [7:0] PERIOD_OFS = 8'h39;

  // Reset values and writable bits
  localparam logic [15:0] MODE_RESET = 16'h2000;
  localparam logic [15:0] MODE_WMASK = 16'ha77c;
  localparam logic [15:0] FILT_RESET = 16'h0000;
  localparam logic [15:0] FILT_WMASK = 16'h8f7f;

  // Master clock source codes
  typedef enum logic [1:0] {
    CLK_INT = 2'h0,
    CLK_INT_OUT = 2'h1,
    CLK_EXT = 2'h2,
    CLK_XTAL = 2'h3
  } acsdf_clk_src_t;

  // Filter order codes
  localparam logic [1:0] ORD_SINC5_SINC1 = 2'h0;
  localparam logic [1:0] ORD_SINC3 = 2'h3;

  // Mode control register layout
  typedef struct packed {
    logic ref_en;
    logic rsv14;
    logic single_cycle_settle;
    logic [1:0] rsv12;
    logic [2:0] delay;
    logic rsv7;
    logic [2:0] mode;
    acsdf_clk_src_t master_clock_source_select;
    logic [1:0] rsv0;
  } acsdf_mode_t;

  // Filter configuration register layout, normal mapping
  typedef struct packed {
    logic sinc3_direct_decimation_map;
    logic [2:0] rsv12;
    logic enh_en;
    logic [2:0] enh_sel;
    logic rsv7;
    logic [1:0] order;
    logic [4:0] odr;
  } acsdf_filt_t;

  // Rate result handed to the sequencer
  typedef struct packed {
    logic [23:0] period;
    logic [1:0] settle;
  } acsdf_rate_t;

  // Clock rates
  localparam int unsigned REF_CLK_HZ = 250_000_000;
  localparam int unsigned OSC_HZ = 16_000_000;
  localparam int unsigned MCLK_HZ = 2_000_000;
  localparam int unsigned MOD_HZ = MCLK_HZ / 2;
  localparam logic [8:0] OSC_ACC_MOD = 9'(REF_CLK_HZ / 1_000_000);
  localparam logic [8:0] OSC_ACC_STEP = 9'(2 * OSC_HZ / 1_000_000);
  localparam logic [2:0] MCLK_DIV_LAST = 3'(OSC_HZ / MCLK_HZ - 1);

  // Filter constants
  localparam int unsigned SINC5_ODR_HZ = 31_250;
  localparam logic [5:0] SINC5_DEC = 6'(MOD_HZ / SINC5_ODR_HZ);
  localparam int unsigned ODR_SINGLE_MAX_HZ = 2_600;
  localparam logic [5:0] SINC1_SINGLE_MIN =
    6'((SINC5_ODR_HZ + ODR_SINGLE_MAX_HZ - 1) / ODR_SINGLE_MAX_HZ);
  localparam logic [1:0] SINC3_SETTLE = 2'h3;
  localparam logic [1:0] SINC5_FAST_SETTLE = 2'h2;
  localparam logic [1:0] ONE_SETTLE = 2'h1;
  localparam logic [3:0] SINC3_ODR_STEP = 4'h8;
  localparam logic [14:0] SINC3_MIN_DEC = 15'h0001;

  // Enhanced filter periods in modulator ticks, rates in centi-SPS, milli-SPS for ENH_T3
  localparam logic [23:0] ENH_T0 = 24'(MOD_HZ * 100 / 2727);
  localparam logic [23:0] ENH_T1 = 24'(MOD_HZ * 100 / 2500);
  localparam logic [23:0] ENH_T2 = 24'(MOD_HZ * 100 / 2000);
  localparam logic [23:0] ENH_T3 = 24'(MOD_HZ * 1000 / 16667);

endpackage

// ---- design/acsdf_clk_sel.sv ----
// Master clock source selection and divide-down to master and modulator enables
`timescale 1ns/1ps
module acsdf_clk_sel (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Source choice
  input wire acsdf_pkg::acsdf_clk_src_t clk_src,
  // Pins
  input wire logic crystal_input_pin,
  input wire logic clock_io_in,
  output logic clock_io_out,
  output logic clock_io_oe,
  // Derived enables
  output logic mclk_en,
  output logic mod_en
);

  logic [8:0] acc_ff, nxt_acc;
  logic osc_lvl_ff, nxt_osc_lvl;
  logic xtal_d_ff, nxt_xtal_d;
  logic cio_d_ff, nxt_cio_d;
  logic [2:0] div_ff, nxt_div;
  logic mod_ph_ff, nxt_mod_ph;
  logic mclk_ff, nxt_mclk;
  logic mod_ff, nxt_mod;
  logic [1:0] src_ff, nxt_src;

  // Oscillator model, source edge pick, divide by eight except for the external clock, then by two
  always_comb begin
    logic [8:0] sum;
    logic osc_rise;
    logic fast_tick;
    logic mtick;
    sum = acc_ff + acsdf_pkg::OSC_ACC_STEP;
    nxt_acc = sum;
    nxt_osc_lvl = osc_lvl_ff;
    if (sum >= acsdf_pkg::OSC_ACC_MOD) begin
      nxt_acc = sum - acsdf_pkg::OSC_ACC_MOD;
      nxt_osc_lvl = ~osc_lvl_ff;
    end
    osc_rise = (sum >= acsdf_pkg::OSC_ACC_MOD) && !osc_lvl_ff;
    nxt_xtal_d = crystal_input_pin;
    nxt_cio_d = clock_io_in;
    nxt_src = clk_src;
    fast_tick = 1'b0;
    mtick = 1'b0;
    nxt_div = div_ff;
    case (clk_src)
      acsdf_pkg::CLK_INT, acsdf_pkg::CLK_INT_OUT: fast_tick = osc_rise;
      acsdf_pkg::CLK_XTAL: fast_tick = crystal_input_pin && !xtal_d_ff;
      acsdf_pkg::CLK_EXT: mtick = clock_io_in && !cio_d_ff;
      default: fast_tick = osc_rise;
    endcase
    if (clk_src != src_ff) begin
      nxt_div = 3'h0;
      mtick = 1'b0;
    end else if (fast_tick) begin
      nxt_div = div_ff + 3'h1;
      mtick = (div_ff == acsdf_pkg::MCLK_DIV_LAST);
    end
    nxt_mclk = mtick;
    nxt_mod_ph = mtick ? ~mod_ph_ff : mod_ph_ff;
    nxt_mod = mtick && mod_ph_ff;
  end

  // Registers of the clock path
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      acc_ff <= 9'h000;
      osc_lvl_ff <= 1'b0;
      xtal_d_ff <= 1'b0;
      cio_d_ff <= 1'b0;
      div_ff <= 3'h0;
      mod_ph_ff <= 1'b0;
      mclk_ff <= 1'b0;
      mod_ff <= 1'b0;
      src_ff <= acsdf_pkg::CLK_INT;
    end else begin
      acc_ff <= nxt_acc;
      osc_lvl_ff <= nxt_osc_lvl;
      xtal_d_ff <= nxt_xtal_d;
      cio_d_ff <= nxt_cio_d;
      div_ff <= nxt_div;
      mod_ph_ff <= nxt_mod_ph;
      mclk_ff <= nxt_mclk;
      mod_ff <= nxt_mod;
      src_ff <= nxt_src;
    end
  end

  // Oscillator drives the shared pin only in the clock output option
  assign clock_io_out = osc_lvl_ff && (src_ff == acsdf_pkg::CLK_INT_OUT);
  assign clock_io_oe = (src_ff == acsdf_pkg::CLK_INT_OUT);
  assign mclk_en = mclk_ff;
  assign mod_en = mod_ff;

endmodule

// ---- design/acsdf_rate_calc.sv ----
// Output period and settling count from one filter configuration word
`timescale 1ns/1ps
module acsdf_rate_calc (
  // Configuration of the active setup
  input wire logic [15:0] cfg,
  // Period in modulator ticks and settling in output periods
  output acsdf_pkg::acsdf_rate_t rate
);

  // Decimation in sinc5-sized blocks to modulator ticks
  function automatic logic [23:0] dec_ticks(input logic [14:0] dec);
    dec_ticks = 24'(dec) * 24'(acsdf_pkg::SINC5_DEC);
  endfunction

  // Filter type, mapping and rate decode
  always_comb begin
    acsdf_pkg::acsdf_filt_t f;
    logic [14:0] dec;
    logic [5:0] avg;
    f = acsdf_pkg::acsdf_filt_t'(cfg);
    dec = 15'(f.odr) + 15'h0001;
    avg = 6'(f.odr) + 6'h01;
    rate.period = dec_ticks(15'(avg));
    rate.settle = (avg >= acsdf_pkg::SINC1_SINGLE_MIN) ?
      acsdf_pkg::ONE_SETTLE : acsdf_pkg::SINC5_FAST_SETTLE;
    if (f.sinc3_direct_decimation_map) begin
      dec = cfg[14:0];
      if (dec == 15'h0000) begin
        dec = acsdf_pkg::SINC3_MIN_DEC;
      end
      rate.period = dec_ticks(dec);
      rate.settle = acsdf_pkg::SINC3_SETTLE;
    end else if (f.order == acsdf_pkg::ORD_SINC3) begin
      rate.period = dec_ticks(15'(dec * 15'(acsdf_pkg::SINC3_ODR_STEP)));
      rate.settle = acsdf_pkg::SINC3_SETTLE;
    end else if (f.enh_en) begin
      rate.settle = acsdf_pkg::ONE_SETTLE;
      case (f.enh_sel[1:0])
        2'h0: rate.period = acsdf_pkg::ENH_T0;
        2'h1: rate.period = acsdf_pkg::ENH_T1;
        2'h2: rate.period = acsdf_pkg::ENH_T2;
        default: rate.period = acsdf_pkg::ENH_T3;
      endcase
    end
  end

endmodule

// ---- design/acsdf_top.sv ----
// Clock source selection, setup registers and conversion timing of the converter
`timescale 1ns/1ps
module acsdf_top (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Clock pins
  input wire logic crystal_input_pin,
  input wire logic clock_io_in,
  output logic clock_io_out,
  output logic clock_io_oe,
  // Channel side
  input wire logic [2:0] setup_sel,
  input wire logic multi_channel,
  // Conversion timing
  output logic conv_ready,
  output logic conv_settled,
  output logic [2:0] conv_setup,
  output logic mclk_en,
  output logic mod_en,
  // Analog controls
  output logic internal_ref_enable
);

  typedef enum logic [0:0] {
    ST_SETTLE,
    ST_RUN
  } acsdf_state_t;

  // Register file state
  logic [15:0] mode_ff, nxt_mode;
  logic [15:0] filt_ff [acsdf_pkg::NUM_SETUPS];
  logic [15:0] nxt_filt [acsdf_pkg::NUM_SETUPS];
  logic [15:0] rdata_ff, nxt_rdata;
  logic touch_ff, nxt_touch;

  // Sequencer state
  acsdf_state_t state_ff, nxt_state;
  logic [23:0] tick_ff, nxt_tick;
  logic [1:0] per_ff, nxt_per;
  logic [2:0] setup_ff, nxt_setup;
  logic ready_ff, nxt_ready;
  logic settled_ff, nxt_settled;
  logic [7:0] count_ff, nxt_count;

  // Derived values
  acsdf_pkg::acsdf_mode_t mode_s;
  acsdf_pkg::acsdf_rate_t rate;
  logic single_cyc;
  logic restart;

  // Index of a filter configuration register, or out of range
  function automatic logic filt_hit(input logic [7:0] a);
    filt_hit = (a >= acsdf_pkg::FILT_CFG_OFS) &&
      (a < acsdf_pkg::FILT_CFG_OFS + 8'(acsdf_pkg::NUM_SETUPS));
  endfunction

  function automatic logic [2:0] filt_idx(input logic [7:0] a);
    logic [7:0] d;
    d = a - acsdf_pkg::FILT_CFG_OFS;
    filt_idx = d[2:0];
  endfunction

  assign mode_s = acsdf_pkg::acsdf_mode_t'(mode_ff);

  // Source selection and divide chain
  acsdf_clk_sel u_clk_sel (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .clk_src(mode_s.master_clock_source_select),
    .crystal_input_pin(crystal_input_pin),
    .clock_io_in(clock_io_in),
    .clock_io_out(clock_io_out),
    .clock_io_oe(clock_io_oe),
    .mclk_en(mclk_en),
    .mod_en(mod_en)
  );

  // Rate of the setup that the active channel uses
  acsdf_rate_calc u_rate (
    .cfg(filt_ff[setup_ff]),
    .rate(rate)
  );

  // Register writes, read data one cycle after the strobe
  always_comb begin
    nxt_mode = mode_ff;
    nxt_filt = filt_ff;
    nxt_touch = 1'b0;
    nxt_rdata = 16'h0000;
    if (reg_wr) begin
      if (reg_addr == acsdf_pkg::MODE_CTRL_OFS) begin
        nxt_mode = reg_wdata & acsdf_pkg::MODE_WMASK;
        nxt_touch = 1'b1;
      end else if (filt_hit(reg_addr)) begin
        nxt_filt[filt_idx(reg_addr)] = reg_wdata & acsdf_pkg::FILT_WMASK;
        if (reg_wdata[15]) begin
          nxt_filt[filt_idx(reg_addr)] = reg_wdata;
        end
        nxt_touch = 1'b1;
      end
    end
    if (reg_rd) begin
      if (reg_addr == acsdf_pkg::MODE_CTRL_OFS) begin
        nxt_rdata = mode_ff;
      end else if (filt_hit(reg_addr)) begin
        nxt_rdata = filt_ff[filt_idx(reg_addr)];
      end else if (reg_addr == acsdf_pkg::STATUS_OFS) begin
        nxt_rdata = {count_ff, 1'b0, setup_ff, state_ff == ST_RUN,
          settled_ff, mode_s.master_clock_source_select};
      end else if (reg_addr == acsdf_pkg::PERIOD_OFS) begin
        nxt_rdata = rate.period[23:8];
      end
    end
  end

  // Register file flops
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      mode_ff <= acsdf_pkg::MODE_RESET;
      for (int i = 0; i < acsdf_pkg::NUM_SETUPS; i++) begin
        filt_ff[i] <= acsdf_pkg::FILT_RESET;
      end
      rdata_ff <= 16'h0000;
      touch_ff <= 1'b0;
    end else begin
      mode_ff <= nxt_mode;
      filt_ff <= nxt_filt;
      rdata_ff <= nxt_rdata;
      touch_ff <= nxt_touch;
    end
  end

  // Single cycle settling has no effect while channels are sequenced
  assign single_cyc = mode_s.single_cycle_settle && !multi_channel;
  assign restart = touch_ff || (setup_sel != setup_ff);

  // Conversion timing counted in modulator ticks
  always_comb begin
    logic period_end;
    logic last;
    nxt_state = state_ff;
    nxt_tick = tick_ff;
    nxt_per = per_ff;
    nxt_setup = setup_ff;
    nxt_ready = 1'b0;
    nxt_settled = settled_ff;
    nxt_count = count_ff;
    period_end = (tick_ff >= rate.period - 24'h000001);
    last = (per_ff >= rate.settle - 2'h1);
    if (restart) begin
      nxt_state = ST_SETTLE;
      nxt_tick = 24'h000000;
      nxt_per = 2'h0;
      nxt_setup = setup_sel;
      nxt_settled = 1'b0;
    end else if (mod_en) begin
      nxt_tick = tick_ff + 24'h000001;
      if (period_end) begin
        nxt_tick = 24'h000000;
        case (state_ff)
          ST_SETTLE: begin
            if (last) begin
              nxt_state = ST_RUN;
              nxt_per = 2'h0;
              nxt_ready = 1'b1;
              nxt_settled = 1'b1;
            end else begin
              nxt_per = per_ff + 2'h1;
              nxt_ready = !single_cyc;
              nxt_settled = 1'b0;
            end
          end
          ST_RUN: begin
            if (single_cyc && !last) begin
              nxt_per = per_ff + 2'h1;
            end else begin
              nxt_per = 2'h0;
              nxt_ready = 1'b1;
              nxt_settled = 1'b1;
            end
          end
          default: nxt_state = ST_SETTLE;
        endcase
      end
    end
    if (nxt_ready) begin
      nxt_count = count_ff + 8'h01;
    end
  end

  // Sequencer flops
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state_ff <= ST_SETTLE;
      tick_ff <= 24'h000000;
      per_ff <= 2'h0;
      setup_ff <= 3'h0;
      ready_ff <= 1'b0;
      settled_ff <= 1'b0;
      count_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      tick_ff <= nxt_tick;
      per_ff <= nxt_per;
      setup_ff <= nxt_setup;
      ready_ff <= nxt_ready;
      settled_ff <= nxt_settled;
      count_ff <= nxt_count;
    end
  end

  // Outputs
  assign reg_rdata = rdata_ff;
  assign conv_ready = ready_ff;
  assign conv_settled = settled_ff;
  assign conv_setup = setup_ff;
  assign internal_ref_enable = mode_s.ref_en;

endmodule

// ---- tb/acsdf_top_assertions.sv ----
// Assertion checker for the clock select and decimation top level
`timescale 1ns/1ps
module acsdf_checker (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // Pins and conversion timing
  input wire logic clock_io_out,
  input wire logic clock_io_oe,
  input wire logic [2:0] setup_sel,
  input wire logic multi_channel,
  input wire logic conv_ready,
  input wire logic conv_settled,
  input wire logic [2:0] conv_setup,
  input wire logic mclk_en,
  input wire logic mod_en,
  input wire logic internal_ref_enable
);
  logic [15:0] mode_ff;
  logic [15:0] nxt_mode;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // Shadow of the mode register as software wrote it
  always_comb begin
    nxt_mode = mode_ff;
    if (reg_wr && reg_addr == 8'h01) nxt_mode = reg_wdata & acsdf_pkg::MODE_WMASK;
    if (!resetn) nxt_mode = acsdf_pkg::MODE_RESET;
  end
  always_ff @(posedge ref_clk) begin
    mode_ff <= nxt_mode;
  end
  mode_read_a: assert property (reg_rd && reg_addr == 8'h01 |=> reg_rdata == mode_ff)
    else $error("mode read differs from shadow");
  pin_drive_a: assert property ($stable(mode_ff) |-> clock_io_oe == (mode_ff[3:2] == 2'h1))
    else $error("pin enable does not follow source");
  pin_quiet_a: assert property ($stable(mode_ff) && mode_ff[3:2] != 2'h1 |-> !clock_io_out)
    else $error("pin driven while not selected");
  ref_follow_a: assert property ($stable(mode_ff) |-> internal_ref_enable == mode_ff[15])
    else $error("reference enable does not follow mode");
  mclk_pulse_a: assert property (mclk_en |=> !mclk_en)
    else $error("master tick longer than one cycle");
  mod_gap_a: assert property (mod_en |=> !mod_en [*3])
    else $error("modulator ticks too close");
  ready_tick_a: assert property (conv_ready |-> $past(mod_en))
    else $error("result without modulator tick");
  ready_setup_a: assert property (conv_ready |-> conv_setup == $past(setup_sel))
    else $error("result setup mismatch");
  single_settle_a: assert property (conv_ready && mode_ff[13] && !multi_channel
    |-> ##[0:1] conv_settled)
    else $error("unsettled result in single cycle mode");
  restart_clear_a: assert property (reg_wr |-> ##[1:3] !conv_settled)
    else $error("settled flag kept over restart");
  // Main scenarios reached
  ext_tick_c: cover property (mode_ff[3:2] == 2'h2 && mclk_en);
  pin_drive_c: cover property (clock_io_oe);
  single_ready_c: cover property (conv_ready && mode_ff[13] && !multi_channel);
endmodule

bind acsdf_top acsdf_checker i_acsdf_checker (
  .ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .clock_io_out(clock_io_out),
  .clock_io_oe(clock_io_oe), .setup_sel(setup_sel), .multi_channel(multi_channel),
  .conv_ready(conv_ready), .conv_settled(conv_settled), .conv_setup(conv_setup),
  .mclk_en(mclk_en), .mod_en(mod_en), .internal_ref_enable(internal_ref_enable)
);

// ---- tb/acsdf_top_tb.sv ----
// Self-checking bench for the clock select and decimation top level
`timescale 1ns/1ps
module acsdf_top_tb;
  logic ref_clk, resetn, reg_wr, reg_rd, multi_channel, ext_run, co_d;
  logic xtal = 1'b0;
  logic ckin = 1'b0;
  logic clock_io_out, clock_io_oe, conv_ready, conv_settled, mclk_en, mod_en, ref_on;
  logic [7:0] reg_addr;
  logic [7:0] cyc = 8'h00;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic [2:0] setup_sel, conv_setup;
  int n_errors, tests_run, seed, n_mc, n_md, n_co, k0;
  acsdf_top i_acsdf_top (
    .ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .crystal_input_pin(xtal),
    .clock_io_in(ckin), .clock_io_out(clock_io_out), .clock_io_oe(clock_io_oe),
    .setup_sel(setup_sel), .multi_channel(multi_channel), .conv_ready(conv_ready),
    .conv_settled(conv_settled), .conv_setup(conv_setup), .mclk_en(mclk_en),
    .mod_en(mod_en), .internal_ref_enable(ref_on)
  );
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // Pin clocks (external rises every 4 cycles, crystal every 16) and tick counters
  always @(posedge ref_clk) begin
    cyc <= cyc + 8'h01;
    ckin <= ext_run & cyc[1];
    xtal <= cyc[3];
    n_mc <= n_mc + int'(mclk_en);
    n_md <= n_md + int'(mod_en);
    co_d <= clock_io_out;
    n_co <= n_co + int'(clock_io_out & !co_d);
  end
  task stop_test;
    $display("Counts: %0d checks, %0d mismatches", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(string what, logic [31:0] exp, logic [31:0] got);
    tests_run++;
    if (exp !== got) begin
      n_errors++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  // Register port cycles
  task wr(logic [7:0] a, logic [15:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task rd(logic [7:0] a, output logic [15:0] v);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    @(posedge ref_clk);
  endtask
  // Tick counts over a window, one tick of slack for phase
  task clk_rate(int n, int e);
    int a, b;
    repeat (20) @(posedge ref_clk);
    a = n_mc;
    b = n_md;
    repeat (n) @(posedge ref_clk);
    chk("mclk ticks", 1, (n_mc - a - e) inside {[-1:1]});
    chk("mod ticks", 1, (n_md - b - e / 2) inside {[-1:1]});
    $display("Test clock rate %0d done", e);
  endtask
  // Output period in modulator ticks and settling in outputs
  function automatic void model(logic [15:0] c, output int p, output int s);
    if (c[15]) begin
      p = 32 * ((c[14:0] == 15'h0000) ? 1 : int'(c[14:0]));
      s = 3;
    end else if (c[6:5] == 2'h3) begin
      p = 256 * (int'(c[4:0]) + 1);
      s = 3;
    end else if (c[11]) begin
      p = 1_000_000_000 / ((c[9:8] == 2'h0) ? 27270 : (c[9:8] == 2'h1) ? 25000 :
        (c[9:8] == 2'h2) ? 20000 : 16667);
      s = 1;
    end else begin
      p = 32 * (int'(c[4:0]) + 1);
      s = (int'(c[4:0]) + 1 >= 13) ? 1 : 2;
    end
  endfunction
  task wait_rdy(int lim, output int t, output logic sd);
    int t0, k;
    t0 = n_md;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (conv_ready !== 1'b1 && k < lim);
    t = n_md - t0;
    sd = conv_settled;
    if (k >= lim) begin
      n_errors++;
      $display("BAD conv_ready expected pulse seen none");
      stop_test;
    end
  endtask
  // Select a setup, optionally program it, then follow k outputs
  task run_cfg(logic [2:0] s, logic [15:0] c, logic m, logic w, int k);
    int p, st, t, q;
    logic sd;
    logic [15:0] v;
    model(c, p, st);
    q = p;
    if (!m) begin
      p = p * st;
      st = 1;
    end
    setup_sel <= s;
    multi_channel <= m;
    if (w) begin
      wr(8'(acsdf_pkg::FILT_CFG_OFS + 8'(s)), c);
      rd(8'(acsdf_pkg::FILT_CFG_OFS + 8'(s)), v);
      chk("filter word", c[15] ? c : c & acsdf_pkg::FILT_WMASK, v);
    end else @(posedge ref_clk);
    for (int i = 1; i <= k; i++) begin
      wait_rdy(p * 10 + 100, t, sd);
      if (i > 1) chk("period", p, t);
      chk("settled", i >= st, sd);
      chk("setup", s, conv_setup);
    end
    rd(acsdf_pkg::PERIOD_OFS, v);
    chk("period reg", q >> 8, v);
    rd(acsdf_pkg::STATUS_OFS, v);
    chk("status", {s, 2'h2}, {v[6:4], v[1:0]});
    $display("Test setup %0d word %h done", s, c);
  endtask
  initial begin
    seed = 99903;
    resetn = 1'b0;
    {reg_wr, reg_rd, ext_run} = 3'h0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    setup_sel = 3'h0;
    multi_channel = 1'b1;
    n_errors = 0;
    tests_run = 0;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    rd(8'h01, d);
    chk("mode reset", 16'h2000, d);
    chk("ref off", 0, ref_on);
    chk("pin idle", 0, clock_io_oe);
    $display("Test reset defaults done");
    clk_rate(1280, 10);
    wr(8'h01, 16'hffff);
    rd(8'h01, d);
    chk("mode mask", 16'ha77c, d);
    chk("ref on", 1, ref_on);
    clk_rate(1280, 10);
    for (int c = 0; c < 4; c++) begin
      wr(8'h01, 16'(c) << 2);
      repeat (4) @(posedge ref_clk);
      chk("pin drive", c == 1, clock_io_oe);
      k0 = n_co;
      repeat (250) @(posedge ref_clk);
      chk("pin clock", 1, (n_co - k0 - ((c == 1) ? 16 : 0)) inside {[-1:1]});
    end
    $display("Test pin drive done");
    // Second reset in mid-run must bring back the internal oscillator
    resetn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    rd(acsdf_pkg::MODE_CTRL_OFS, d);
    chk("mode after reset", 16'h2000, d);
    chk("pin after reset", 0, clock_io_oe);
    $display("Test second reset done");
    rd(8'h02, d);
    chk("unmapped read", 0, d);
    ext_run <= 1'b1;
    wr(8'h01, 16'h2008);
    clk_rate(400, 100);
    run_cfg(3'h0, 16'h0000, 1'b1, 1'b1, 3);
    run_cfg(3'h1, 16'h8000, 1'b1, 1'b1, 4);
    run_cfg(3'h2, 16'h8003, 1'b1, 1'b1, 4);
    run_cfg(3'h3, 16'h0060, 1'b1, 1'b1, 4);
    run_cfg(3'h4, 16'h0060, 1'b0, 1'b1, 3);
    run_cfg(3'h5, 16'h000c, 1'b0, 1'b1, 3);
    run_cfg(3'h2, 16'h8003, 1'b1, 1'b0, 3);
    run_cfg(3'h6, 16'h0900, 1'b1, 1'b1, 0);
    for (int i = 0; i < 4; i++) begin
      run_cfg(3'($random(seed)), 16'($random(seed)) & 16'h0007, 1'b1, 1'b1, 3);
    end
    stop_test;
  end
endmodule
